// ==== rtl/pwtm_top.sv ====
// Pulse width timer with AXI4-Lite register slave.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pwtm_params.svh"

module pwtm_top
  import pwtm_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic [3:0]    meas_in_i,
  input  wire logic          alt_clk_i,
  input  wire logic [AW-1:0] s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  input  wire logic [AW-1:0] s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  output logic               irq_o
);

  // Word-aligned address decode, shared by the read and write paths.
  function automatic logic [3:0] addr_word(input logic [AW-1:0] a);
    logic [3:0] w;
    w = 4'h8;
    if (a[1:0] == 2'h0 && a < AW'(8'h20)) begin
      w = {1'b0, a[4:2]};
    end
    return w;
  endfunction

  // Prescaler terminal value for a divide of two to the power of the field.
  function automatic logic [`PWTM_PSC_W-1:0] psc_top(input logic [2:0] p);
    logic [`PWTM_PSC_W-1:0] m;
    m = (`PWTM_PSC_W'(1) << p) - `PWTM_PSC_W'(1);
    return m;
  endfunction

  // Configuration and status storage.
  logic                   clk_sel_reg;
  logic [1:0]             in_sel_reg;
  logic [2:0]             pre_reg;
  logic                   tgl_reg;
  logic                   lvl_reg;
  logic                   en_reg;
  logic                   ie_reg;
  logic                   rdyie_reg;
  logic                   ovie_reg;
  logic                   first_load_enable_reg;
  logic                   rdy_reg;
  logic                   ov_reg;
  logic                   rdy_armed_reg;
  logic                   upd_pend_reg;
  pwtm_state_t            state_reg;

  // Datapath storage.
  logic [3:0]             meas_s1_reg;
  logic [3:0]             meas_s2_reg;
  logic                   alt_s1_reg;
  logic                   alt_s2_reg;
  logic                   alt_prev_reg;
  logic                   sel_prev_reg;
  logic [`PWTM_PSC_W-1:0] psc_reg;
  logic [15:0]            cnt_reg;
  logic                   clr_pend_reg;
  logic                   adv_seen_reg;
  logic [15:0]            pos_reg;
  logic [15:0]            neg_reg;
  logic [15:0]            pos_buf_reg;
  logic [15:0]            neg_buf_reg;
  logic [7:0]             cnt_lo_latch_reg;

  // Bus channel storage.
  logic [AW-1:0]          awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;

  // Combinational controls.
  logic                   sel_lvl;
  logic                   in_edge;
  logic                   src_tick;
  logic                   adv;
  logic                   ov_set;
  logic                   cap_pos;
  logic                   cap_neg;
  logic                   cap_any;
  logic                   do_wr;
  logic                   do_rd;
  logic [3:0]             wr_word;
  logic [3:0]             rd_word;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   soft_clr;
  logic                   rdy_clr_try;
  logic [15:0]            pos_next;
  logic [15:0]            neg_next;
  pwtm_ctrl_t             ctrl_view;
  pwtm_stat_t             stat_view;
  logic [7:0]             rd_byte;

  // Bus handshakes: a write runs once address and data are both held and no response waits.
  assign do_wr    = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign do_rd    = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_word  = addr_word(awaddr_reg);
  assign rd_word  = addr_word(s_axi_araddr_i);
  assign wr_ctrl  = do_wr && wstrb_reg[0] && wr_word == addr_word(AW'(`PWTM_OFS_CTRL));
  assign wr_stat  = do_wr && wstrb_reg[0] && wr_word == addr_word(AW'(`PWTM_OFS_STAT));

  // Soft reset pulse or a cleared enable both hold the measurement logic at rest.
  assign soft_clr = (wr_stat && wdata_reg[`PWTM_CS_SR]) || !en_reg;

  // Input mux reads only the second synchroniser stage.
  assign sel_lvl  = meas_s2_reg[in_sel_reg];
  assign in_edge  = (sel_lvl != sel_prev_reg) && state_reg != PWTM_ST_HALT;

  // Alternative clock is sampled and counted on its rising edges.
  assign src_tick = clk_sel_reg ? (alt_s2_reg && !alt_prev_reg) : 1'b1;
  assign adv      = src_tick && psc_reg == psc_top(pre_reg);
  assign ov_set   = adv && !clr_pend_reg && state_reg != PWTM_ST_HALT && cnt_reg == `PWTM_CNT_MAX;

  // The pulse that just ended had the level seen before the edge.
  assign cap_any  = in_edge && (state_reg == PWTM_ST_MEAS || first_load_enable_reg);
  assign cap_pos  = cap_any && sel_prev_reg;
  assign cap_neg  = cap_any && !sel_prev_reg;
  assign pos_next = cap_pos ? cnt_reg : pos_reg;
  assign neg_next = cap_neg ? cnt_reg : neg_reg;

  // A clear counts only after the flag was read as set.
  assign rdy_clr_try = wr_stat && !wdata_reg[`PWTM_CS_RDY] && rdy_armed_reg && rdy_reg;

  // Register read views.
  assign ctrl_view = '{clk_sel: clk_sel_reg, in_sel: in_sel_reg, tgl: tgl_reg, lvl: lvl_reg, pre: pre_reg};
  assign stat_view = '{en: en_reg, ie: ie_reg, rdyie: rdyie_reg, ovie: ovie_reg, sr: 1'b0,
                       first_load_enable: first_load_enable_reg, rdy: rdy_reg, ov: ov_reg};

  // Read data mux; width registers are seen only through their buffers.
  always_comb begin
    case (rd_word)
      4'h0:    rd_byte = ctrl_view;
      4'h1:    rd_byte = stat_view;
      4'h2:    rd_byte = pos_buf_reg[15:8];
      4'h3:    rd_byte = pos_buf_reg[7:0];
      4'h4:    rd_byte = neg_buf_reg[15:8];
      4'h5:    rd_byte = neg_buf_reg[7:0];
      4'h6:    rd_byte = cnt_reg[15:8];
      4'h7:    rd_byte = cnt_lo_latch_reg;
      default: rd_byte = `PWTM_BYTE_ZERO;
    endcase
  end

  // Two-stage synchronisers for the pins; only the second stage feeds logic.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meas_s1_reg  <= 4'h0;
      meas_s2_reg  <= 4'h0;
      alt_s1_reg   <= 1'b0;
      alt_s2_reg   <= 1'b0;
      alt_prev_reg <= 1'b0;
    end else if (ce_i) begin
      meas_s1_reg  <= meas_in_i;
      meas_s2_reg  <= meas_s1_reg;
      alt_s1_reg   <= alt_clk_i;
      alt_s2_reg   <= alt_s1_reg;
      alt_prev_reg <= alt_s2_reg;
    end
  end

  // Write address and data channels are taken in either order.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `PWTM_RESP_OKAY;
      awaddr_reg      <= '0;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_reg      <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_reg      <= s_axi_wdata_i;
        wstrb_reg      <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_word[3] ? `PWTM_RESP_DECERR : `PWTM_RESP_OKAY;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `PWTM_RESP_OKAY;
    end else if (ce_i) begin
      if (do_rd) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= {24'h000000, rd_byte};
        s_axi_rresp_o   <= rd_word[3] ? `PWTM_RESP_DECERR : `PWTM_RESP_OKAY;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Software settings; soft reset leaves them alone.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sel_reg <= 1'b0;
      in_sel_reg  <= 2'h0;
      pre_reg     <= 3'h0;
      en_reg      <= 1'b0;
      ie_reg      <= 1'b0;
      rdyie_reg   <= 1'b0;
      ovie_reg    <= 1'b0;
      first_load_enable_reg   <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        clk_sel_reg <= wdata_reg[`PWTM_CR_CLKSEL];
        in_sel_reg  <= wdata_reg[`PWTM_CR_INSEL_HI:`PWTM_CR_INSEL_LO];
        pre_reg     <= wdata_reg[`PWTM_CR_PRE_HI:`PWTM_CR_PRE_LO];
      end
      if (wr_stat) begin
        en_reg    <= wdata_reg[`PWTM_CS_EN];
        ie_reg    <= wdata_reg[`PWTM_CS_IE];
        rdyie_reg <= wdata_reg[`PWTM_CS_RDYIE];
        ovie_reg  <= wdata_reg[`PWTM_CS_OVIE];
        first_load_enable_reg <= wdata_reg[`PWTM_CS_FIRST_LOAD_ENABLE];
      end
    end
  end

  // Measurement phase: enable restarts it at the first-edge phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PWTM_ST_HALT;
    end else if (ce_i) begin
      if (soft_clr) begin
        state_reg <= PWTM_ST_HALT;
      end else begin
        case (state_reg)
          PWTM_ST_HALT:  state_reg <= PWTM_ST_FIRST;
          PWTM_ST_FIRST: if (in_edge) state_reg <= PWTM_ST_MEAS;
          PWTM_ST_MEAS:  state_reg <= PWTM_ST_MEAS;
          default:       state_reg <= PWTM_ST_HALT;
        endcase
      end
    end
  end

  // Edge tracking, prescaler and counter. The restart lands one cycle after the
  // upload; the tick taken at the upload edge is carried into the new count, and a tick in
  // the restart cycle only when the prescaler divides by one, so only then is no count lost across a capture.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_prev_reg <= 1'b0;
      psc_reg      <= '0;
      cnt_reg      <= `PWTM_CNT_ZERO;
      clr_pend_reg <= 1'b0;
      adv_seen_reg <= 1'b0;
    end else if (ce_i) begin
      sel_prev_reg <= sel_lvl;
      if (soft_clr) begin
        psc_reg      <= '0;
        cnt_reg      <= `PWTM_CNT_ZERO;
        clr_pend_reg <= 1'b0;
        adv_seen_reg <= 1'b0;
      end else begin
        clr_pend_reg <= in_edge;
        adv_seen_reg <= adv && !clr_pend_reg && state_reg != PWTM_ST_HALT;
        if (clr_pend_reg) begin
          psc_reg <= '0;
          cnt_reg <= {14'h0000, 2'(adv_seen_reg) + 2'(src_tick && psc_top(pre_reg) == '0)};
        end else if (state_reg != PWTM_ST_HALT) begin
          if (src_tick) begin
            psc_reg <= adv ? '0 : psc_reg + `PWTM_PSC_W'(1);
          end
          if (adv) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
    end
  end

  // Width registers load on every capture, whatever the ready flag says.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_reg <= `PWTM_CNT_ZERO;
      neg_reg <= `PWTM_CNT_ZERO;
    end else if (ce_i) begin
      if (soft_clr) begin
        pos_reg <= `PWTM_CNT_ZERO;
        neg_reg <= `PWTM_CNT_ZERO;
      end else begin
        pos_reg <= pos_next;
        neg_reg <= neg_next;
      end
    end
  end

  // Ready flag and read buffers. A capture while ready is set is remembered, and a
  // later clear attempt then fails and refreshes the buffers instead of losing it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_reg       <= 1'b0;
      upd_pend_reg  <= 1'b0;
      rdy_armed_reg <= 1'b0;
      pos_buf_reg   <= `PWTM_CNT_ZERO;
      neg_buf_reg   <= `PWTM_CNT_ZERO;
    end else if (ce_i) begin
      if (soft_clr) begin
        rdy_reg       <= 1'b0;
        upd_pend_reg  <= 1'b0;
        rdy_armed_reg <= 1'b0;
        pos_buf_reg   <= `PWTM_CNT_ZERO;
        neg_buf_reg   <= `PWTM_CNT_ZERO;
      end else begin
        if (do_rd && rd_word == 4'h1 && rdy_reg) begin
          rdy_armed_reg <= 1'b1;
        end else if (wr_stat) begin
          rdy_armed_reg <= 1'b0;
        end
        if (cap_any && !rdy_reg) begin
          rdy_reg     <= 1'b1;
          pos_buf_reg <= pos_next;
          neg_buf_reg <= neg_next;
        end else if (rdy_clr_try && (cap_any || upd_pend_reg)) begin
          pos_buf_reg  <= pos_next;
          neg_buf_reg  <= neg_next;
          upd_pend_reg <= 1'b0;
        end else if (rdy_clr_try) begin
          rdy_reg <= 1'b0;
        end else if (cap_any) begin
          upd_pend_reg <= 1'b1;
        end
      end
    end
  end

  // Overflow, toggle and level status; a set in the clear cycle wins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_reg  <= 1'b0;
      tgl_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else if (ce_i) begin
      if (soft_clr) begin
        ov_reg  <= 1'b0;
        tgl_reg <= 1'b0;
        lvl_reg <= 1'b0;
      end else begin
        if (ov_set) begin
          ov_reg  <= 1'b1;
          lvl_reg <= sel_lvl;
        end else if (wr_stat && !wdata_reg[`PWTM_CS_OV]) begin
          ov_reg <= 1'b0;
        end
        if (in_edge) begin
          tgl_reg <= 1'b1;
        end else if (wr_ctrl && !wdata_reg[`PWTM_CR_TGL]) begin
          tgl_reg <= 1'b0;
        end
      end
    end
  end

  // Counter low byte is frozen when the high byte is read.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_lo_latch_reg <= `PWTM_BYTE_ZERO;
    end else if (ce_i) begin
      if (soft_clr) begin
        cnt_lo_latch_reg <= `PWTM_BYTE_ZERO;
      end else if (do_rd && rd_word == 4'h6) begin
        cnt_lo_latch_reg <= cnt_reg[7:0];
      end
    end
  end

  // Interrupt request, registered so the output comes from a flip-flop.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= ie_reg && ((ov_reg && ovie_reg) || (rdy_reg && rdyie_reg));
    end
  end

  // Checks on the measurement and status behaviour.
  chk_ovf_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ov_set && !soft_clr |=> ov_reg && cnt_reg == `PWTM_CNT_ZERO)
    else $error("Overflow did not set the flag and wrap the counter.");

  chk_ovf_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ov_set && !soft_clr |=> lvl_reg == $past(sel_lvl))
    else $error("Level bit does not match the input at overflow.");

  chk_cap_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && in_edge && !soft_clr ##1 ce_i && !soft_clr |=> cnt_reg <= 16'h0002 && psc_reg == '0)
    else $error("Counter was not restarted one cycle after capture.");

  chk_first_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !soft_clr && state_reg == PWTM_ST_FIRST && in_edge && !first_load_enable_reg
    |=> $stable(pos_reg) && $stable(neg_reg))
    else $error("First count was stored with first-load off.");

  chk_rdy_on_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !soft_clr && cap_any |=> rdy_reg)
    else $error("Ready flag not set after a capture.");

  chk_buf_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !soft_clr && rdy_reg && !rdy_clr_try |=> $stable(pos_buf_reg) && $stable(neg_buf_reg))
    else $error("Read buffers changed while ready was set.");

  chk_clr_fails: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !soft_clr && rdy_clr_try && cap_any |=> rdy_reg && pos_buf_reg == pos_reg)
    else $error("Clear with a new capture did not fail and refresh.");

  chk_soft_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && soft_clr |=> cnt_reg == `PWTM_CNT_ZERO && !rdy_reg && !ov_reg && !tgl_reg && pos_buf_reg == '0)
    else $error("Soft reset left measurement state behind.");

  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 irq_o |-> $past(ie_reg) && ($past(ov_reg && ovie_reg) || $past(rdy_reg && rdyie_reg)))
    else $error("Interrupt raised without an enabled cause.");

endmodule // pwtm_top

// ==== include/pwtm_params.svh ====
// Offsets, field positions and reset values of the pulse width timer.
`ifndef PWTM_PARAMS_SVH
`define PWTM_PARAMS_SVH

// Byte offsets of the register words on the AXI4-Lite slave.
`define PWTM_OFS_CTRL      8'h00
`define PWTM_OFS_STAT      8'h04
`define PWTM_OFS_POS_HI    8'h08
`define PWTM_OFS_POS_LO    8'h0C
`define PWTM_OFS_NEG_HI    8'h10
`define PWTM_OFS_NEG_LO    8'h14
`define PWTM_OFS_CNT_HI    8'h18
`define PWTM_OFS_CNT_LO    8'h1C

// Control register field positions.
`define PWTM_CR_CLKSEL     7
`define PWTM_CR_INSEL_HI   6
`define PWTM_CR_INSEL_LO   5
`define PWTM_CR_TGL        4
`define PWTM_CR_LVL        3
`define PWTM_CR_PRE_HI     2
`define PWTM_CR_PRE_LO     0

// Control and status register field positions.
`define PWTM_CS_EN         7
`define PWTM_CS_IE         6
`define PWTM_CS_RDYIE      5
`define PWTM_CS_OVIE       4
`define PWTM_CS_SR         3
`define PWTM_CS_FIRST_LOAD_ENABLE      2
`define PWTM_CS_RDY        1
`define PWTM_CS_OV         0

// Widths and reset values.
`define PWTM_CNT_W         16
`define PWTM_PSC_W         7
`define PWTM_CNT_MAX       16'hFFFF
`define PWTM_CNT_ZERO      16'h0000
`define PWTM_BYTE_ZERO     8'h00

// AXI response codes.
`define PWTM_RESP_OKAY     2'h0
`define PWTM_RESP_DECERR   2'h3

`endif

// ==== include/pwtm_pkg.sv ====
// Types shared by the pulse width timer design.
package pwtm_pkg;

  // Read view of the control register, bit 7 first.
  typedef struct packed {
    logic       clk_sel;
    logic [1:0] in_sel;
    logic       tgl;
    logic       lvl;
    logic [2:0] pre;
  } pwtm_ctrl_t;

  // Read view of the control and status register, bit 7 first.
  typedef struct packed {
    logic en;
    logic ie;
    logic rdyie;
    logic ovie;
    logic sr;
    logic first_load_enable;
    logic rdy;
    logic ov;
  } pwtm_stat_t;

  // Measurement phase after enable.
  typedef enum logic [1:0] {
    PWTM_ST_HALT,
    PWTM_ST_FIRST,
    PWTM_ST_MEAS
  } pwtm_state_t;

endpackage

// ==== tb/pwtm_pulse_src.sv ====
// Pulse source that drives the four measured inputs.
`timescale 1ns/1ns
module pwtm_pulse_src (
  input  wire logic        clk_i,
  input  wire logic [1:0]  lane_i,
  input  wire logic [15:0] hi_i,
  input  wire logic [15:0] lo_i,
  output logic [3:0]       pin_o
);
  logic        lvl_reg;
  logic [15:0] cnt_reg;

  // Zero high time holds low, zero low time holds high, else a square wave.
  always_ff @(posedge clk_i) begin
    if (hi_i == 16'h0000) begin
      lvl_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (lo_i == 16'h0000) begin
      lvl_reg <= 1'b1;
    end else if (cnt_reg >= (lvl_reg ? hi_i : lo_i) - 16'h0001) begin
      lvl_reg <= ~lvl_reg;
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Unselected lanes show the inverse so a wrong select is seen.
  always_comb begin
    pin_o         = {4{~lvl_reg}};
    pin_o[lane_i] = lvl_reg;
  end
endmodule // pwtm_pulse_src

// ==== tb/pwtm_top_tb.sv ====
// Self-checking bench for the pulse width timer.
`timescale 1ns/1ns
`include "pwtm_params.svh"
module pwtm_top_tb;
  logic clk_i, rst_i, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr, irq, alt;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  pins;
  logic [15:0] hi, lo;
  int num_errors = 0, n_checks = 0;

  pwtm_pulse_src u_src (.clk_i(clk_i), .lane_i(2'h2), .hi_i(hi), .lo_i(lo), .pin_o(pins));
  pwtm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .meas_in_i(pins), .alt_clk_i(alt),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .irq_o(irq));

  // Clock of 4 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write and address are released each on its own handshake; the response code lands in r.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_i);
    awa <= a;
    wd  <= {24'h0, v};
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (awv && awr) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr_r) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk_i); while (!bv);
    r = bresp;
    br <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge clk_i);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    rd(a);
    chk({24'h0, e}, d, n);
  endtask

  task automatic t_map;
    rc(`PWTM_OFS_CTRL, 8'h00, "ctrl reset");
    rc(`PWTM_OFS_STAT, 8'h00, "stat reset");
    rd(8'h20);
    chk(32'h3, {30'h0, r}, "unmapped resp");
    wr(8'h20, 8'hFF);
    chk(32'h3, {30'h0, r}, "wr unmapped resp");
  endtask

  // Widths 20 high and 30 low on lane 2; the first clear must fail.
  task automatic t_measure;
    wr(`PWTM_OFS_CTRL, 8'h40);
    hi <= 16'h0014; lo <= 16'h001E;
    wr(`PWTM_OFS_STAT, 8'h80);
    repeat (300) @(posedge clk_i);
    rc(`PWTM_OFS_STAT, 8'h82, "ready set");
    wr(`PWTM_OFS_STAT, 8'h80);
    rc(`PWTM_OFS_STAT, 8'h82, "clear fails");
    rc(`PWTM_OFS_POS_LO, 8'h14, "pos width");
    rc(`PWTM_OFS_NEG_LO, 8'h1E, "neg width");
    hi <= 16'h0000;
    repeat (100) @(posedge clk_i);
    repeat (2) begin
      rd(`PWTM_OFS_STAT);
      wr(`PWTM_OFS_STAT, 8'h80);
    end
    rc(`PWTM_OFS_STAT, 8'h80, "clear ok");
  endtask

  // Input held low until the counter wraps.
  task automatic t_overflow;
    repeat (66000) @(posedge clk_i);
    rc(`PWTM_OFS_STAT, 8'h81, "ov set");
    rc(`PWTM_OFS_CTRL, 8'h50, "toggle low ov");
    wr(`PWTM_OFS_STAT, 8'hD1);
    repeat (3) @(posedge clk_i);
    chk(32'h1, {31'h0, irq}, "irq on");
    wr(`PWTM_OFS_STAT, 8'hD0);
    rc(`PWTM_OFS_STAT, 8'hD0, "ov cleared");
    chk(32'h0, {31'h0, irq}, "irq off");
  endtask

  // Alternative clock at divide by two: five source edges must give a count of two.
  task automatic t_soft;
    wr(`PWTM_OFS_CTRL, 8'hC1);
    wr(`PWTM_OFS_STAT, 8'h88);
    rc(`PWTM_OFS_STAT, 8'h80, "sr reads 0");
    rc(`PWTM_OFS_POS_LO, 8'h00, "width clr");
    rc(`PWTM_OFS_CTRL, 8'hC1, "ctrl kept");
    repeat (5) begin
      alt <= 1'b1;
      repeat (4) @(posedge clk_i);
      alt <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    rc(`PWTM_OFS_CNT_HI, 8'h00, "cnt hi");
    rc(`PWTM_OFS_CNT_LO, 8'h02, "cnt lo");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog sized above the overflow wait.
  initial begin
    #380000;
    num_errors++;
    complete_run;
  end

  // Reset for three cycles, then the scenarios.
  initial begin
    rst_i = 1'b1;
    awv   = 1'b0;
    wv    = 1'b0;
    br    = 1'b0;
    arv   = 1'b0;
    rr    = 1'b0;
    alt   = 1'b0;
    awa   = 8'h00;
    ara   = 8'h00;
    wd    = 32'h0;
    hi    = 16'h0000;
    lo    = 16'h0000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_map;
    t_measure;
    t_overflow;
    t_soft;
    complete_run;
  end
endmodule // pwtm_top_tb
